// ===== logic/scc_static_cs_ctrl.v
// Purpose: Static memory chip-select engine with per-chip-select configuration over APB.
// Assumes: All inputs synchronous to I_REF_CLK; both resets synchronous, active low.
// Notes: Configuration fields are loaded by power-on reset only; bus reset clears the engine.
//
// What this block does
// - Reserved config bits read zero, write zero.
// - Bit 20 write-protects chip select, reset 0.
// - Bit 19 enables write buffer, reset 0.
// - Bit 8 selects long-wait timing for all.
// - Mode 0: reads strobes high, writes active low.
// - Mode 1: active lanes low on reads too.
// - Power-on loads mode 0 for CS 0,2,3.
// - CS1 mode loads from strap, software overrides.
// - Bus reset leaves strap-loaded mode unchanged.
// - 16-bit byte selects: write matching, reads matching in mode 1.
`include "scc_static_cs_defines.vh"

module scc_static_cs_ctrl (
	input wire I_REF_CLK,
	input wire I_RST_N,
	input wire I_POWER_ON_RESET_N,
	input wire I_CS1_LANE_STROBE_STRAP,
	input wire I_PSEL,
	input wire I_PENABLE,
	input wire I_PWRITE,
	input wire [11:0] I_PADDR,
	input wire [31:0] I_PWDATA,
	output reg [31:0] O_PRDATA,
	output reg O_PREADY,
	output reg O_PSLVERR,
	input wire I_REQ_VALID,
	input wire I_REQ_WRITE,
	input wire [1:0] I_REQ_CS,
	input wire [23:0] I_REQ_ADDR,
	input wire [3:0] I_REQ_LANES,
	input wire [31:0] I_REQ_WDATA,
	output reg O_REQ_READY,
	output reg O_RESP_VALID,
	output reg O_RESP_ERR,
	output reg [31:0] O_RESP_RDATA,
	output reg [3:0] O_CS_N,
	output reg [23:0] O_MEM_ADDR,
	output reg [31:0] O_MEM_DOUT,
	output reg O_MEM_DOUT_EN_N,
	input wire [31:0] I_MEM_DIN,
	output reg O_OUTPUT_ENABLE_N,
	output reg O_MEMORY_WRITE_STROBE_N,
	output reg [3:0] O_LANE_STROBE_OUT_N
);

	// Per-chip-select configuration fields, one bit per chip select.
	wire [3:0] write_protect;
	wire [3:0] write_buffer;
	wire [3:0] long_wait_select;
	wire [3:0] lane_strobe_read_mode;

	// Power-on values per chip select; chip select 1 takes its lane mode from the strap.
	wire [3:0] protect_rst;
	wire [3:0] buffer_rst;
	wire [3:0] long_rst;
	wire [3:0] lane_rst;
	wire [3:0] cfg_wr_sel;

	// Timing registers shared by all chip selects.
	reg [`SCC_SHORT_WAIT_W-1:0] read_wait_reg;
	reg [`SCC_SHORT_WAIT_W-1:0] write_wait_reg;
	reg [`SCC_LONG_WAIT_W-1:0] long_wait_count_reg;

	// Engine state.
	reg state;
	reg [`SCC_LONG_WAIT_W-1:0] count;
	reg cur_write;
	reg cur_buffered;

	wire engine_rst;
	wire apb_access;
	wire apb_commit;
	wire apb_wr;
	wire cfg_hit;
	wire [1:0] cfg_idx;
	wire req_take;
	wire req_protected;
	wire req_buffered;
	reg [31:0] next_prdata;
	reg next_pslverr;
	reg [`SCC_LONG_WAIT_W-1:0] next_wait;
	reg [3:0] next_read_lanes_n;

	assign engine_rst = !I_RST_N || !I_POWER_ON_RESET_N;
	assign protect_rst = `SCC_WRITE_PROTECT_RST;
	assign buffer_rst = `SCC_WRITE_BUFFER_RST;
	assign long_rst = `SCC_LONG_WAIT_SELECT_RST;
	assign lane_rst = {2'b00, I_CS1_LANE_STROBE_STRAP, 1'b0};

	// APB: one wait state; the transfer completes on the second access cycle.
	assign apb_access = I_PSEL && I_PENABLE;
	assign apb_commit = apb_access && O_PREADY;
	assign apb_wr = apb_commit && I_PWRITE && !O_PSLVERR;
	assign cfg_hit = (I_PADDR[11:4] == 8'h00) && (I_PADDR[1:0] == 2'b00);
	assign cfg_idx = I_PADDR[3:2];

	always @(posedge I_REF_CLK) begin
		if (!engine_rst) begin
			O_PREADY <= apb_access && !O_PREADY;
		end else begin
			O_PREADY <= 1'b0;
		end
	end

	// Read data and error for the addressed register.
	always @* begin
		next_prdata = 32'h0000_0000;
		next_pslverr = 1'b0;
		if (cfg_hit) begin
			next_prdata[`SCC_WRITE_PROTECT_BIT] = write_protect[cfg_idx];
			next_prdata[`SCC_WRITE_BUFFER_BIT] = write_buffer[cfg_idx];
			next_prdata[`SCC_LONG_WAIT_SELECT_BIT] = long_wait_select[cfg_idx];
			next_prdata[`SCC_LANE_STROBE_READ_MODE_BIT] = lane_strobe_read_mode[cfg_idx];
		end else begin
			case (I_PADDR)
				`SCC_READ_WAIT_OFS: begin
					next_prdata[`SCC_SHORT_WAIT_W-1:0] = read_wait_reg;
				end
				`SCC_WRITE_WAIT_OFS: begin
					next_prdata[`SCC_SHORT_WAIT_W-1:0] = write_wait_reg;
				end
				`SCC_LONG_WAIT_OFS: begin
					next_prdata[`SCC_LONG_WAIT_W-1:0] = long_wait_count_reg;
				end
				`SCC_STATUS_OFS: begin
					next_prdata[`SCC_STAT_BUSY_BIT] = (state == `SCC_ST_ACCESS);
					next_prdata[`SCC_STAT_BUFFERED_BIT] = cur_buffered;
				end
				default: begin
					next_pslverr = 1'b1;
				end
			endcase
		end
	end

	// Read data and error are registered alongside pready and hold until the next access.
	always @(posedge I_REF_CLK) begin
		if (engine_rst) begin
			O_PRDATA <= 32'h0000_0000;
			O_PSLVERR <= 1'b0;
		end else if (apb_access && !O_PREADY) begin
			O_PRDATA <= I_PWRITE ? 32'h0000_0000 : next_prdata;
			O_PSLVERR <= next_pslverr;
		end
	end

	// One configuration slot per chip select, written only by its own word.
	assign cfg_wr_sel = (apb_wr && cfg_hit) ? (4'h1 << cfg_idx) : 4'h0;

	genvar k;
	generate
		for (k = 0; k < 4; k = k + 1) begin : g_cfg_slot
			scc_cs_cfg_slot scc_cs_cfg_slot_inst (
				.i_clk(I_REF_CLK),
				.i_por_n(I_POWER_ON_RESET_N),
				.i_wr(cfg_wr_sel[k]),
				.i_wdata(I_PWDATA),
				.i_protect_rst(protect_rst[k]),
				.i_buffer_rst(buffer_rst[k]),
				.i_long_rst(long_rst[k]),
				.i_lane_rst(lane_rst[k]),
				.o_write_protect(write_protect[k]),
				.o_write_buffer(write_buffer[k]),
				.o_long_wait_select(long_wait_select[k]),
				.o_lane_strobe_read_mode(lane_strobe_read_mode[k])
			);
		end
	endgenerate

	// Timing registers.
	always @(posedge I_REF_CLK) begin
		if (engine_rst) begin
			read_wait_reg <= `SCC_READ_WAIT_RST;
			write_wait_reg <= `SCC_WRITE_WAIT_RST;
			long_wait_count_reg <= `SCC_LONG_WAIT_RST;
		end else if (apb_wr) begin
			case (I_PADDR)
				`SCC_READ_WAIT_OFS: begin
					read_wait_reg <= I_PWDATA[`SCC_SHORT_WAIT_W-1:0];
				end
				`SCC_WRITE_WAIT_OFS: begin
					write_wait_reg <= I_PWDATA[`SCC_SHORT_WAIT_W-1:0];
				end
				`SCC_LONG_WAIT_OFS: begin
					long_wait_count_reg <= I_PWDATA[`SCC_LONG_WAIT_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Request decode. The configuration of the chip select is sampled once at acceptance,
	// so a change made while the engine is busy only affects the next access.
	assign req_take = I_REQ_VALID && O_REQ_READY;
	assign req_protected = I_REQ_WRITE && write_protect[I_REQ_CS];
	assign req_buffered = I_REQ_WRITE && write_buffer[I_REQ_CS];

	always @* begin
		if (long_wait_select[I_REQ_CS]) begin
			next_wait = long_wait_count_reg;
		end else if (I_REQ_WRITE) begin
			next_wait = {{(`SCC_LONG_WAIT_W-`SCC_SHORT_WAIT_W){1'b0}}, write_wait_reg};
		end else begin
			next_wait = {{(`SCC_LONG_WAIT_W-`SCC_SHORT_WAIT_W){1'b0}}, read_wait_reg};
		end
	end

	// Read lane strobes: high in mode 0 so byte-wide write strobes and byte selects stay off.
	always @* begin
		if (lane_strobe_read_mode[I_REQ_CS]) begin
			next_read_lanes_n = ~I_REQ_LANES;
		end else begin
			next_read_lanes_n = 4'hf;
		end
	end

	// Memory access engine. An access holds its strobes for the wait count plus one cycle.
	always @(posedge I_REF_CLK) begin
		if (engine_rst) begin
			state <= `SCC_ST_IDLE;
			count <= {`SCC_LONG_WAIT_W{1'b0}};
			cur_write <= 1'b0;
			cur_buffered <= 1'b0;
			O_REQ_READY <= 1'b1;
			O_RESP_VALID <= 1'b0;
			O_RESP_ERR <= 1'b0;
			O_RESP_RDATA <= 32'h0000_0000;
			O_CS_N <= 4'hf;
			O_MEM_ADDR <= 24'h00_0000;
			O_MEM_DOUT <= 32'h0000_0000;
			O_MEM_DOUT_EN_N <= 1'b1;
			O_OUTPUT_ENABLE_N <= 1'b1;
			O_MEMORY_WRITE_STROBE_N <= 1'b1;
			O_LANE_STROBE_OUT_N <= 4'hf;
		end else begin
			O_RESP_VALID <= 1'b0;
			case (state)
				`SCC_ST_IDLE: begin
					if (req_take) begin
						O_RESP_ERR <= req_protected;
						if (req_protected) begin
							// Refused at once; no chip select, data or strobe moves.
							O_RESP_VALID <= 1'b1;
						end else begin
							state <= `SCC_ST_ACCESS;
							O_REQ_READY <= 1'b0;
							count <= next_wait;
							cur_write <= I_REQ_WRITE;
							cur_buffered <= req_buffered;
							// A buffered write is acknowledged before it reaches memory.
							O_RESP_VALID <= req_buffered;
							O_CS_N <= ~(4'h1 << I_REQ_CS);
							O_MEM_ADDR <= I_REQ_ADDR;
							if (I_REQ_WRITE) begin
								O_MEM_DOUT <= I_REQ_WDATA;
								O_MEM_DOUT_EN_N <= 1'b0;
								O_MEMORY_WRITE_STROBE_N <= 1'b0;
								O_LANE_STROBE_OUT_N <= ~I_REQ_LANES;
							end else begin
								O_OUTPUT_ENABLE_N <= 1'b0;
								O_LANE_STROBE_OUT_N <= next_read_lanes_n;
							end
						end
					end
				end
				`SCC_ST_ACCESS: begin
					if (count == {`SCC_LONG_WAIT_W{1'b0}}) begin
						state <= `SCC_ST_IDLE;
						O_REQ_READY <= 1'b1;
						cur_buffered <= 1'b0;
						O_CS_N <= 4'hf;
						O_MEM_DOUT_EN_N <= 1'b1;
						O_OUTPUT_ENABLE_N <= 1'b1;
						O_MEMORY_WRITE_STROBE_N <= 1'b1;
						O_LANE_STROBE_OUT_N <= 4'hf;
						if (!cur_write) begin
							O_RESP_RDATA <= I_MEM_DIN;
							O_RESP_VALID <= 1'b1;
						end else begin
							O_RESP_VALID <= !cur_buffered;
						end
					end else begin
						count <= count - {{(`SCC_LONG_WAIT_W-1){1'b0}}, 1'b1};
					end
				end
				default: begin
					state <= `SCC_ST_IDLE;
					O_REQ_READY <= 1'b1;
				end
			endcase
		end
	end

endmodule // scc_static_cs_ctrl

// One chip select's configuration bits. They follow power-on reset only,
// so a bus reset leaves software's settings and the strap-loaded mode alone.
// The reset values come in as inputs because chip select 1 loads a strap.
module scc_cs_cfg_slot (
	input wire i_clk,
	input wire i_por_n,
	input wire i_wr,
	input wire [31:0] i_wdata,
	input wire i_protect_rst,
	input wire i_buffer_rst,
	input wire i_long_rst,
	input wire i_lane_rst,
	output reg o_write_protect,
	output reg o_write_buffer,
	output reg o_long_wait_select,
	output reg o_lane_strobe_read_mode
);

	always @(posedge i_clk) begin
		if (!i_por_n) begin
			o_write_protect <= i_protect_rst;
			o_write_buffer <= i_buffer_rst;
			o_long_wait_select <= i_long_rst;
			o_lane_strobe_read_mode <= i_lane_rst;
		end else if (i_wr) begin
			// Only the implemented bits are stored; reserved bits are dropped.
			o_write_protect <= i_wdata[`SCC_WRITE_PROTECT_BIT];
			o_write_buffer <= i_wdata[`SCC_WRITE_BUFFER_BIT];
			o_long_wait_select <= i_wdata[`SCC_LONG_WAIT_SELECT_BIT];
			o_lane_strobe_read_mode <= i_wdata[`SCC_LANE_STROBE_READ_MODE_BIT];
		end
	end

endmodule // scc_cs_cfg_slot

// ===== logic/scc_static_cs_defines.vh
// Purpose: Constants for the static chip-select configuration block.
// Assumes: APB byte addresses, 32-bit data, one aligned word per register.
// Notes: Field positions refer to the per-chip-select configuration word and the status word.
`ifndef SCC_STATIC_CS_DEFINES_VH
`define SCC_STATIC_CS_DEFINES_VH

// Register byte offsets.
`define SCC_CFG0_OFS 12'h000
`define SCC_CFG1_OFS 12'h004
`define SCC_CFG2_OFS 12'h008
`define SCC_CFG3_OFS 12'h00c
`define SCC_READ_WAIT_OFS 12'h010
`define SCC_WRITE_WAIT_OFS 12'h014
`define SCC_LONG_WAIT_OFS 12'h018
`define SCC_STATUS_OFS 12'h01c

// Configuration word field positions.
`define SCC_WRITE_PROTECT_BIT 20
`define SCC_WRITE_BUFFER_BIT 19
`define SCC_LONG_WAIT_SELECT_BIT 8
`define SCC_LANE_STROBE_READ_MODE_BIT 7

// Status word field positions.
`define SCC_STAT_BUSY_BIT 0
`define SCC_STAT_BUFFERED_BIT 1

// Field widths and reset values.
`define SCC_SHORT_WAIT_W 5
`define SCC_LONG_WAIT_W 10
`define SCC_READ_WAIT_RST 5'h1f
`define SCC_WRITE_WAIT_RST 5'h1f
`define SCC_LONG_WAIT_RST 10'h000
`define SCC_WRITE_PROTECT_RST 4'h0
`define SCC_WRITE_BUFFER_RST 4'h0
`define SCC_LONG_WAIT_SELECT_RST 4'h0

// Memory access engine states.
`define SCC_ST_IDLE 1'b0
`define SCC_ST_ACCESS 1'b1

`endif

// ===== tb/scc_mem_model.sv
// Purpose: Static memory seen through chip-select, strobes and data pins.
// Assumes: One memory for all chip selects, 16 words deep.
// Notes: Data pins change every cycle while not driven for a read.
module scc_mem_model (
	input wire logic I_REF_CLK,
	input wire logic [3:0] O_CS_N,
	input wire logic [23:0] O_MEM_ADDR,
	input wire logic [31:0] O_MEM_DOUT,
	input wire logic O_MEMORY_WRITE_STROBE_N,
	input wire logic O_OUTPUT_ENABLE_N,
	input wire logic [3:0] O_LANE_STROBE_OUT_N,
	output logic [31:0] I_MEM_DIN
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] mem [0:15];
	logic [31:0] junk = 32'h5a5a5a5a;
	wire sel = O_CS_N != 4'hf;
	always @(posedge I_REF_CLK) begin
		junk <= ~junk;
		for (int i = 0; i < 4; i++)
			if (sel && !O_MEMORY_WRITE_STROBE_N && !O_LANE_STROBE_OUT_N[i])
				mem[O_MEM_ADDR[3:0]][8*i+:8] <= O_MEM_DOUT[8*i+:8];
	end
	assign I_MEM_DIN = (sel && !O_OUTPUT_ENABLE_N) ? mem[O_MEM_ADDR[3:0]] : junk;
endmodule // scc_mem_model

// ===== tb/scc_static_cs_ctrl_sva.sv
// Purpose: Port-level checks of strobes, refusals and register reads.
// Assumes: One clock; either reset disables the checks.
// Notes: Bound to the controller below.
module scc_static_cs_ctrl_sva (
	input wire I_REF_CLK, I_RST_N, I_POWER_ON_RESET_N, I_PSEL, I_PENABLE, I_PWRITE,
	input wire [11:0] I_PADDR,
	input wire I_REQ_VALID, I_REQ_WRITE,
	input wire [3:0] I_REQ_LANES, O_CS_N, O_LANE_STROBE_OUT_N,
	input wire [31:0] O_PRDATA,
	input wire O_PREADY, O_REQ_READY, O_RESP_VALID, O_RESP_ERR,
	input wire O_MEM_DOUT_EN_N, O_OUTPUT_ENABLE_N, O_MEMORY_WRITE_STROBE_N
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RST_N || !I_POWER_ON_RESET_N);
	wire acc = I_REQ_VALID && O_REQ_READY;
	a_wp_quiet: assert property (O_RESP_VALID && O_RESP_ERR |->
		O_CS_N == 4'hf && O_LANE_STROBE_OUT_N == 4'hf && O_REQ_READY) else $error("pins moved");
	a_err_write: assert property (O_RESP_VALID && O_RESP_ERR |->
		$past(acc && I_REQ_WRITE)) else $error("error not on write");
	a_write_lanes: assert property (acc && I_REQ_WRITE ##1 !O_MEMORY_WRITE_STROBE_N |->
		O_LANE_STROBE_OUT_N == ~$past(I_REQ_LANES)) else $error("write lanes");
	a_read_lanes: assert property (acc && !I_REQ_WRITE |=> O_LANE_STROBE_OUT_N == 4'hf ||
		O_LANE_STROBE_OUT_N == ~$past(I_REQ_LANES)) else $error("read lanes");
	a_oe_quiet: assert property (!O_OUTPUT_ENABLE_N |->
		O_MEMORY_WRITE_STROBE_N && O_MEM_DOUT_EN_N) else $error("write during read");
	a_strobe_cs: assert property (!O_MEMORY_WRITE_STROBE_N |->
		!O_MEM_DOUT_EN_N && O_CS_N != 4'hf) else $error("strobe without select");
	a_idle_lanes: assert property (O_CS_N == 4'hf |-> O_LANE_STROBE_OUT_N == 4'hf)
		else $error("lanes while idle");
	a_cfg_rsv: assert property (O_PREADY && !I_PWRITE && I_PADDR < 12'h010 |->
		O_PRDATA[31:21] == 0 && O_PRDATA[18:9] == 0) else $error("reserved bits set");
	cover property (O_RESP_VALID && O_RESP_ERR);
	cover property (!O_OUTPUT_ENABLE_N && O_LANE_STROBE_OUT_N != 4'hf);
	cover property (!O_MEMORY_WRITE_STROBE_N);
endmodule // scc_static_cs_ctrl_sva
bind scc_static_cs_ctrl scc_static_cs_ctrl_sva scc_static_cs_ctrl_sva_inst (.*);

// ===== tb/scc_static_cs_ctrl_tb_top.sv
// Purpose: Self-checking bench for the static chip-select controller.
// Assumes: Register writes only while the engine is idle.
// Notes: Chip select 0 stands for a byte-wide part.
module scc_static_cs_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic I_REF_CLK = 0, I_RST_N = 0, I_POWER_ON_RESET_N = 0, I_CS1_LANE_STROBE_STRAP = 1;
	logic I_PSEL = 0, I_PENABLE = 0, I_PWRITE = 0, I_REQ_VALID = 0, I_REQ_WRITE = 0;
	logic [11:0] I_PADDR = 0;
	logic [31:0] I_PWDATA = 0, I_REQ_WDATA = 0, O_PRDATA, O_RESP_RDATA, O_MEM_DOUT, I_MEM_DIN, rd;
	logic [1:0] I_REQ_CS = 0;
	logic [23:0] I_REQ_ADDR = 0, O_MEM_ADDR;
	logic [3:0] I_REQ_LANES = 0, O_CS_N, O_LANE_STROBE_OUT_N, ls;
	logic O_PREADY, O_PSLVERR, O_REQ_READY, O_RESP_VALID, O_RESP_ERR, e;
	logic O_MEM_DOUT_EN_N, O_OUTPUT_ENABLE_N, O_MEMORY_WRITE_STROBE_N;
	int fails = 0, n_checks = 0, cyc = 0, n;
	always #50 I_REF_CLK = ~I_REF_CLK;
	scc_static_cs_ctrl scc_static_cs_ctrl_inst (.*);
	scc_mem_model scc_mem_model_inst (.*);
	task chk(input logic [31:0] s, input logic [31:0] x);
		n_checks++;
		if (s !== x) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	task results;
		if (fails == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge I_REF_CLK) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			results();
		end
	end
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		I_PSEL <= 1;
		I_PENABLE <= 0;
		I_PWRITE <= w;
		I_PADDR <= a;
		I_PWDATA <= d;
		@(posedge I_REF_CLK);
		I_PENABLE <= 1;
		do @(posedge I_REF_CLK); while (O_PREADY !== 1'b1);
		rd = O_PRDATA;
		e = O_PSLVERR;
		I_PSEL <= 0;
		I_PENABLE <= 0;
		@(posedge I_REF_CLK);
	endtask
	task mreq(input logic w, input logic [1:0] cs, input logic [3:0] ln, input logic [31:0] d);
		I_REQ_VALID <= 1;
		I_REQ_WRITE <= w;
		I_REQ_CS <= cs;
		I_REQ_LANES <= ln;
		I_REQ_WDATA <= d;
		do @(posedge I_REF_CLK); while (O_REQ_READY !== 1'b1);
		I_REQ_VALID <= 0;
		n = 1;
		@(posedge I_REF_CLK);
		ls = O_LANE_STROBE_OUT_N;
		while (O_RESP_VALID !== 1'b1) begin
			@(posedge I_REF_CLK);
			n++;
		end
		rd = O_RESP_RDATA;
	endtask
	initial begin
		repeat (16) @(posedge I_REF_CLK);
		I_RST_N <= 1;
		I_POWER_ON_RESET_N <= 1;
		@(posedge I_REF_CLK);
		for (int i = 0; i < 4; i++) begin
			apb(0, 12'(4 * i), 0);
			chk(rd, i == 1 ? 32'h80 : 32'h0);
		end
		mreq(1, 0, 4'hf, 32'h11223344);
		mreq(1, 0, 4'h5, 32'haabbccdd);
		chk(ls, 4'ha);
		mreq(0, 0, 4'h3, 0);
		chk(ls, 4'hf);
		chk(rd, 32'h11bb33dd);
		chk(n, 33);
		mreq(0, 1, 4'h3, 0);
		chk(ls, 4'hc);
		apb(1, 12'h018, 3);
		apb(1, 12'h00c, 32'h100);
		mreq(0, 3, 4'h1, 0);
		chk(n, 5);
		apb(1, 12'h008, 32'h100000);
		mreq(1, 2, 4'hf, 0);
		chk({ls, O_CS_N, 3'b0, O_RESP_ERR}, 12'hff1);
		apb(1, 12'h000, 32'h80000);
		mreq(1, 0, 4'h1, 0);
		chk(n, 1);
		while (O_REQ_READY !== 1'b1) @(posedge I_REF_CLK);
		apb(1, 12'h004, 32'hffffffff);
		apb(0, 12'h004, 0);
		chk(rd, 32'h00180180);
		apb(1, 12'h004, 0);
		I_RST_N <= 0;
		@(posedge I_REF_CLK);
		I_RST_N <= 1;
		@(posedge I_REF_CLK);
		apb(0, 12'h004, 0);
		chk(rd, 0);
		I_POWER_ON_RESET_N <= 0;
		@(posedge I_REF_CLK);
		I_POWER_ON_RESET_N <= 1;
		@(posedge I_REF_CLK);
		apb(0, 12'h004, 0);
		chk(rd, 32'h80);
		apb(0, 12'h040, 0);
		chk(e, 1);
		results();
	end
endmodule // scc_static_cs_ctrl_tb_top
